// >>> hw/uart_shadow_data_port.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Operation
// - read returns byte from serial or infrared
// - sixteen word aliases reach one data port
// - read data valid only while data ready
// - no fifo: new byte overwrites, flags overrun
// - fifo mode: read returns oldest entry
// - full fifo keeps contents, drops byte, overrun
// - written byte goes to serial or infrared
// - no fifo: one write clears holding empty
// - no fifo: further writes replace waiting byte
// - fifo mode accepts sixteen bytes before full
// - write to full transmit fifo is dropped
module uart_shadow_data_port import uart_shadow_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [7:0] rx_ser_byte_i,
	input wire logic rx_ser_valid_i,
	input wire logic [7:0] rx_ir_byte_i,
	input wire logic rx_ir_valid_i,
	input wire logic tx_ready_i,
	output logic [7:0] tx_ser_byte_o,
	output logic tx_ser_valid_o,
	output logic [7:0] tx_ir_byte_o,
	output logic tx_ir_valid_o,
	output logic data_ready_flag_o,
	output logic tx_holding_empty_flag_o,
	output logic fifo_en_o,
	output logic ir_mode_o,
	output logic overrun_o,
	output logic irq_o
);
	bus_state_t state_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [1:0] fifo_control_reg_r;
	logic [7:0] rx_hold_r;
	logic rx_full_r;
	logic [7:0] tx_hold_r;
	logic tx_full_r;
	logic overrun_r;
	logic [7:0] tx_ser_byte_r;
	logic tx_ser_valid_r;
	logic [7:0] tx_ir_byte_r;
	logic tx_ir_valid_r;
	logic data_ready_r;
	logic tx_empty_r;
	logic [7:0] rx_ff_head;
	logic [FIFO_CNT_W-1:0] rx_ff_count;
	logic rx_ff_full;
	logic rx_ff_empty;
	logic [7:0] tx_ff_head;
	logic [FIFO_CNT_W-1:0] tx_ff_count;
	logic tx_ff_full;
	logic tx_ff_empty;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic irq_line;

	// bus phases and address decode
	wire setup = psel_i & ~penable_i;
	wire done = psel_i & penable_i & (state_r == BUS_ANSWER);
	wire hit_alias = in_alias(paddr_i);
	wire hit_fctl = word_hit(paddr_i, FIFO_CONTROL_REG_ADDR);
	wire hit_lstat = word_hit(paddr_i, LINE_STATUS_REG_ADDR);
	wire hit_ist = word_hit(paddr_i, IRQ_STATUS_ADDR);
	wire hit_imk = word_hit(paddr_i, IRQ_MASK_ADDR);
	wire hit_any = hit_alias | hit_fctl | hit_lstat | hit_ist | hit_imk;
	wire lane0 = pstrb_i[0];
	// only the low byte lane reaches the data port
	wire wr_data = done & pwrite_i & hit_alias & lane0;
	wire rd_data = done & ~pwrite_i & hit_alias;
	wire wr_fctl = done & pwrite_i & hit_fctl & lane0;
	wire rd_lstat = done & ~pwrite_i & hit_lstat;
	wire wr_ist = done & pwrite_i & hit_ist & lane0;
	wire wr_imk = done & pwrite_i & hit_imk & lane0;

	wire fifo_en = fifo_control_reg_r[FIFO_EN_BIT];
	wire ir_mode = fifo_control_reg_r[IR_MODE_BIT];
	// switching fifo mode drops whatever was pending, as on a classic uart
	wire flush = wr_fctl & (pwdata_i[FIFO_EN_BIT] != fifo_en);

	// receive source follows the infrared mode bit
	wire rx_in_valid = ir_mode ? rx_ir_valid_i : rx_ser_valid_i;
	wire [7:0] rx_in_byte = ir_mode ? rx_ir_byte_i : rx_ser_byte_i;

	// full fifo refuses the byte inside byte_fifo
	wire rx_push = fifo_en & rx_in_valid & ~flush;
	wire rx_pop = fifo_en & rd_data;
	// data ready qualifies the read data
	wire data_ready = fifo_en ? ~rx_ff_empty : rx_full_r;
	// head of fifo or the single holding byte
	wire [7:0] rx_head = fifo_en ? rx_ff_head : rx_hold_r;
	// overrun when storage is still occupied
	wire ovr_evt = rx_in_valid & ~flush &
		(fifo_en ? rx_ff_full : (rx_full_r & ~rd_data));
	wire rx_arrive = rx_in_valid & ~flush & (fifo_en ? ~rx_ff_full : 1'b1);

	wire tx_avail = fifo_en ? ~tx_ff_empty : tx_full_r;
	wire [7:0] tx_head = fifo_en ? tx_ff_head : tx_hold_r;
	// at most one byte every other ready cycle; valid stays low a cycle between bytes
	wire tx_launch = tx_ready_i & tx_avail & ~tx_ser_valid_r & ~tx_ir_valid_r & ~flush;
	// full transmit fifo drops the push inside byte_fifo
	wire tx_push = fifo_en & wr_data & ~flush;
	wire tx_pop = fifo_en & tx_launch;
	wire tx_empty = ~tx_avail;
	wire [IRQ_W-1:0] irq_events = {tx_empty & ~tx_empty_r, ovr_evt, rx_arrive};

	wire [31:0] line_status_word = {26'h0, tx_empty, 3'h0, overrun_r, data_ready};
	wire [31:0] rd_mux =
		hit_alias ? {24'h0, rx_head} :
		hit_fctl ? {30'h0, fifo_control_reg_r} :
		hit_lstat ? line_status_word :
		hit_ist ? {29'h0, irq_status} :
		hit_imk ? {29'h0, irq_mask} : 32'h0;

	byte_fifo rx_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(flush),
		.push_i(rx_push),
		.data_i(rx_in_byte),
		.pop_i(rx_pop),
		.head_o(rx_ff_head),
		.count_o(rx_ff_count),
		.full_o(rx_ff_full),
		.empty_o(rx_ff_empty)
	);

	byte_fifo tx_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(flush),
		.push_i(tx_push),
		.data_i(pwdata_i[7:0]),
		.pop_i(tx_pop),
		.head_o(tx_ff_head),
		.count_o(tx_ff_count),
		.full_o(tx_ff_full),
		.empty_o(tx_ff_empty)
	);

	sticky_irq irq_ctrl (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(irq_events),
		.clear_wr_i(wr_ist),
		.mask_wr_i(wr_imk),
		.wdata_i(pwdata_i[IRQ_W-1:0]),
		.status_o(irq_status),
		.mask_o(irq_mask),
		.irq_o(irq_line)
	);

	// read data is sampled at setup, one access cycle, no wait states
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= BUS_IDLE;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			case (state_r)
				BUS_IDLE: begin
					if (setup) begin
						state_r <= BUS_ANSWER;
						pready_r <= 1'b1;
						pslverr_r <= ~hit_any;
						prdata_r <= pwrite_i ? 32'h0 : rd_mux;
					end
				end
				BUS_ANSWER: begin
					if (psel_i && penable_i) begin
						state_r <= BUS_IDLE;
						pready_r <= 1'b0;
						pslverr_r <= 1'b0;
					end
				end
				default: begin
					state_r <= BUS_IDLE;
					pready_r <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_control_reg_r <= FIFO_CONTROL_RESET;
		end else if (wr_fctl) begin
			fifo_control_reg_r <= pwdata_i[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || flush) begin
			rx_hold_r <= SHADOW_RX_TX_DATA_RESET[7:0];
			rx_full_r <= 1'b0;
		end else if (!fifo_en && rx_in_valid) begin
			rx_hold_r <= rx_in_byte;
			rx_full_r <= 1'b1;
		end else if (!fifo_en && rd_data) begin
			rx_full_r <= 1'b0;
		end
	end

	// overrun sticks until line status is read; a new overrun wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overrun_r <= 1'b0;
		end else begin
			overrun_r <= ovr_evt | (overrun_r & ~rd_lstat);
		end
	end

	// a write fills the holding byte and clears empty
	// later writes replace the waiting byte
	always_ff @(posedge clk_i) begin
		if (rst_i || flush) begin
			tx_hold_r <= SHADOW_RX_TX_DATA_RESET[7:0];
			tx_full_r <= 1'b0;
		end else if (!fifo_en && wr_data) begin
			tx_hold_r <= pwdata_i[7:0];
			tx_full_r <= 1'b1;
		end else if (!fifo_en && tx_launch) begin
			tx_full_r <= 1'b0;
		end
	end

	// byte leaves on the serial or infrared path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_ser_byte_r <= 8'h00;
			tx_ser_valid_r <= 1'b0;
			tx_ir_byte_r <= 8'h00;
			tx_ir_valid_r <= 1'b0;
		end else begin
			tx_ser_valid_r <= tx_launch & ~ir_mode;
			tx_ir_valid_r <= tx_launch & ir_mode;
			if (tx_launch) begin
				tx_ser_byte_r <= tx_head;
				tx_ir_byte_r <= tx_head;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_ready_r <= 1'b0;
			tx_empty_r <= 1'b1;
		end else begin
			data_ready_r <= data_ready;
			tx_empty_r <= tx_empty;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign tx_ser_byte_o = tx_ser_byte_r;
	assign tx_ser_valid_o = tx_ser_valid_r;
	assign tx_ir_byte_o = tx_ir_byte_r;
	assign tx_ir_valid_o = tx_ir_valid_r;
	assign data_ready_flag_o = data_ready_r;
	assign tx_holding_empty_flag_o = tx_empty_r;
	assign fifo_en_o = fifo_control_reg_r[FIFO_EN_BIT];
	assign ir_mode_o = fifo_control_reg_r[IR_MODE_BIT];
	assign overrun_o = overrun_r;
	assign irq_o = irq_line;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_alias_ready_next: assert property (
		setup && hit_alias |=> pready_o && !pslverr_o)
		else $error("alias access not answered cleanly");

	a_upper_bits_zero: assert property (
		setup && !pwrite_i && hit_alias |=> prdata_o[31:8] == 24'h0)
		else $error("data port upper bits not zero");

	a_rx_mode_source: assert property (
		rx_ir_valid_i && ir_mode && !fifo_en && !flush && !wr_fctl
		|=> rx_hold_r == $past(rx_ir_byte_i) && rx_full_r)
		else $error("infrared byte not captured");

	a_ready_qualifies: assert property (
		rd_data && !fifo_en && !rx_in_valid |=> !rx_full_r)
		else $error("data ready not cleared by read");

	a_overrun_flagged: assert property (
		rx_in_valid && !fifo_en && rx_full_r && !rd_data && !flush
		|=> overrun_r && rx_hold_r == $past(rx_in_byte))
		else $error("overwrite without overrun");

	a_fifo_head_read: assert property (
		setup && !pwrite_i && hit_alias && fifo_en |=> prdata_o[7:0] == $past(rx_ff_head))
		else $error("read did not return fifo head");

	a_rx_full_keeps: assert property (
		rx_in_valid && fifo_en && rx_ff_full && !rx_pop && !flush
		|=> $stable(rx_ff_count) && overrun_r)
		else $error("full rx fifo changed on arrival");

	a_tx_path_mode: assert property (
		tx_launch |=> {tx_ir_valid_o, tx_ser_valid_o} == {$past(ir_mode), !$past(ir_mode)}
		&& tx_ser_byte_o == $past(tx_head))
		else $error("transmit byte misrouted");

	a_empty_clears: assert property (
		wr_data && !fifo_en && !flush |=> !tx_empty && tx_hold_r == $past(pwdata_i[7:0]))
		else $error("holding empty not cleared by write");

	a_tx_depth_limit: assert property (
		tx_ff_count <= FIFO_CNT_W'(FIFO_DEPTH))
		else $error("transmit fifo over depth");

	a_tx_full_drop: assert property (
		wr_data && fifo_en && tx_ff_full && !tx_pop && !flush |=> $stable(tx_ff_count))
		else $error("write to full tx fifo stored");
endmodule : uart_shadow_data_port

// >>> hw/uart_shadow_pkg.sv
package uart_shadow_pkg;

	// sixteen word aliases of the receive buffer / transmit holding pair
	localparam logic [31:0] ALIAS_BASE_ADDR = 32'h5000_1130;
	localparam logic [31:0] ALIAS_SPAN = 32'h0000_0040;
	localparam logic [31:0] SHADOW_RX_TX_DATA_3_ADDR = 32'h5000_113c;
	localparam logic [31:0] SHADOW_RX_TX_DATA_4_ADDR = 32'h5000_1140;
	localparam logic [15:0] SHADOW_RX_TX_DATA_RESET = 16'h0000;

	// control, status and interrupt words
	localparam logic [31:0] FIFO_CONTROL_REG_ADDR = 32'h5000_1100;
	localparam logic [31:0] LINE_STATUS_REG_ADDR = 32'h5000_1104;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5000_1108;
	localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000_110c;

	localparam int FIFO_EN_BIT = 0;
	localparam int IR_MODE_BIT = 1;
	localparam logic [1:0] FIFO_CONTROL_RESET = 2'h0;

	localparam int STATUS_DATA_READY_BIT = 0;
	localparam int STATUS_OVERRUN_BIT = 1;
	localparam int STATUS_TX_EMPTY_BIT = 5;

	localparam int IRQ_W = 3;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_OVERRUN_BIT = 1;
	localparam int IRQ_TX_EMPTY_BIT = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_PTR_W = 4;
	localparam int FIFO_CNT_W = 5;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_t;

	function automatic logic in_alias(input logic [31:0] addr);
		logic [31:0] delta;
		delta = addr - ALIAS_BASE_ADDR;
		return (delta < ALIAS_SPAN) && (addr[1:0] == 2'b00);
	endfunction : in_alias

	function automatic logic word_hit(input logic [31:0] addr, input logic [31:0] base);
		return addr == base;
	endfunction : word_hit

endpackage : uart_shadow_pkg

// >>> hw/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo import uart_shadow_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic push_i,
	input wire logic [7:0] data_i,
	input wire logic pop_i,
	output logic [7:0] head_o,
	output logic [FIFO_CNT_W-1:0] count_o,
	output logic full_o,
	output logic empty_o
);
	logic [7:0] mem_r [FIFO_DEPTH];
	logic [FIFO_PTR_W-1:0] wr_ptr_r;
	logic [FIFO_PTR_W-1:0] rd_ptr_r;
	logic [FIFO_CNT_W-1:0] count_r;
	wire do_push = push_i & ~full_o;
	wire do_pop = pop_i & ~empty_o;
	wire [FIFO_CNT_W-1:0] count_nxt = count_r + {4'h0, do_push} - {4'h0, do_pop};

	assign full_o = count_r == FIFO_CNT_W'(FIFO_DEPTH);
	assign empty_o = count_r == '0;
	assign head_o = mem_r[rd_ptr_r];
	assign count_o = count_r;

	// a push into a full fifo is dropped, stored entries stay put
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_r[wr_ptr_r] <= data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= do_push ? wr_ptr_r + 4'h1 : wr_ptr_r;
			rd_ptr_r <= do_pop ? rd_ptr_r + 4'h1 : rd_ptr_r;
			count_r <= count_nxt;
		end
	end
endmodule : byte_fifo

// >>> hw/sticky_irq.sv
`timescale 1ns/1ps
module sticky_irq import uart_shadow_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [IRQ_W-1:0] event_i,
	input wire logic clear_wr_i,
	input wire logic mask_wr_i,
	input wire logic [IRQ_W-1:0] wdata_i,
	output logic [IRQ_W-1:0] status_o,
	output logic [IRQ_W-1:0] mask_o,
	output logic irq_o
);
	logic [IRQ_W-1:0] status_r;
	logic [IRQ_W-1:0] mask_r;
	logic irq_r;
	// a new event beats a write-one-to-clear in the same cycle
	wire [IRQ_W-1:0] clear_bits = clear_wr_i ? wdata_i : IRQ_RESET;
	wire [IRQ_W-1:0] status_nxt = event_i | (status_r & ~clear_bits);
	wire [IRQ_W-1:0] mask_nxt = mask_wr_i ? wdata_i : mask_r;

	assign status_o = status_r;
	assign mask_o = mask_r;
	assign irq_o = irq_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r <= IRQ_RESET;
			mask_r <= IRQ_RESET;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq_r <= |(status_nxt & mask_nxt);
		end
	end
endmodule : sticky_irq

// >>> verification/uart_link_partner.sv
`timescale 1ns/1ps
module uart_link_partner (
	input wire logic clk_i,
	input wire logic [7:0] tx_ser_byte_i,
	input wire logic tx_ser_valid_i,
	input wire logic [7:0] tx_ir_byte_i,
	input wire logic tx_ir_valid_i,
	output logic [7:0] rx_ser_byte_o,
	output logic rx_ser_valid_o,
	output logic [7:0] rx_ir_byte_o,
	output logic rx_ir_valid_o,
	output logic tx_ready_o
);
	logic [8:0] got[$];
	initial begin
		rx_ser_byte_o = 8'h00;
		rx_ser_valid_o = 1'b0;
		rx_ir_byte_o = 8'h00;
		rx_ir_valid_o = 1'b0;
		tx_ready_o = 1'b1;
	end
	task automatic set_ready(input logic r);
		tx_ready_o <= r;
	endtask : set_ready
	// idle byte lines show the inverse so a stale byte never looks fresh
	task automatic send(input logic ir, input logic [7:0] b);
		@(posedge clk_i);
		if (ir) begin
			rx_ir_byte_o <= b;
			rx_ir_valid_o <= 1'b1;
		end else begin
			rx_ser_byte_o <= b;
			rx_ser_valid_o <= 1'b1;
		end
		@(posedge clk_i);
		rx_ser_valid_o <= 1'b0;
		rx_ir_valid_o <= 1'b0;
		rx_ser_byte_o <= ~b;
		rx_ir_byte_o <= ~b;
	endtask : send
	// entries carry the path in bit 8: one for infrared
	always @(posedge clk_i) begin
		if (tx_ser_valid_i === 1'b1)
			got.push_back({1'b0, tx_ser_byte_i});
		if (tx_ir_valid_i === 1'b1)
			got.push_back({1'b1, tx_ir_byte_i});
	end
endmodule : uart_link_partner

// >>> verification/uart_shadow_data_port_tb.sv
`timescale 1ns/1ps
module uart_shadow_data_port_tb;
	import uart_shadow_pkg::*;
	logic clk_i, rst_i, psel, penable, pwrite, pready_o, pslverr_o, err;
	logic [31:0] paddr, pwdata, prdata_o, rd;
	logic [3:0] pstrb;
	logic [7:0] rsb, rib, tsb, tib;
	logic rsv, riv, tx_ready, tsv, tiv, data_rdy, tx_empty, fifo_en, ir_mode, ovr, irq_o;
	int fails = 0;
	int n_checks = 0;
	uart_shadow_data_port u_uart_shadow_data_port (.clk_i(clk_i), .rst_i(rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .rx_ser_byte_i(rsb), .rx_ser_valid_i(rsv),
		.rx_ir_byte_i(rib), .rx_ir_valid_i(riv), .tx_ready_i(tx_ready),
		.tx_ser_byte_o(tsb), .tx_ser_valid_o(tsv), .tx_ir_byte_o(tib),
		.tx_ir_valid_o(tiv), .data_ready_flag_o(data_rdy), .tx_holding_empty_flag_o(tx_empty),
		.fifo_en_o(fifo_en), .ir_mode_o(ir_mode), .overrun_o(ovr), .irq_o(irq_o));
	uart_link_partner u_uart_link_partner (.clk_i(clk_i), .tx_ser_byte_i(tsb),
		.tx_ser_valid_i(tsv), .tx_ir_byte_i(tib), .tx_ir_valid_i(tiv),
		.rx_ser_byte_o(rsb), .rx_ser_valid_o(rsv), .rx_ir_byte_o(rib),
		.rx_ir_valid_o(riv), .tx_ready_o(tx_ready));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic results;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		// no fixed wait count: only the watchdog ends a stuck access
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	task automatic irqchk(input logic exp);
		repeat (2) @(posedge clk_i);
		chk(32'(irq_o), 32'(exp));
	endtask : irqchk
	// waits for the far side, then makes sure nothing extra follows
	task automatic wait_tx(input int n);
		for (int i = 0; i < 200 && u_uart_link_partner.got.size() < n; i++)
			@(posedge clk_i);
		repeat (10) @(posedge clk_i);
		chk(32'(u_uart_link_partner.got.size()), 32'(n));
	endtask : wait_tx
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		results();
	end
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(LINE_STATUS_REG_ADDR, 32'h20);
		rdchk(SHADOW_RX_TX_DATA_3_ADDR, {16'h0, SHADOW_RX_TX_DATA_RESET});
		rdchk(FIFO_CONTROL_REG_ADDR, 32'h0);
		apb(1'b0, ALIAS_BASE_ADDR + ALIAS_SPAN, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, IRQ_MASK_ADDR, 32'h1);
		u_uart_link_partner.send(1'b0, 8'h11);
		irqchk(1'b1);
		chk(32'(data_rdy), 32'h1);
		apb(1'b1, IRQ_MASK_ADDR, 32'h0);
		irqchk(1'b0);
		apb(1'b1, IRQ_MASK_ADDR, 32'h1);
		irqchk(1'b1);
		apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
		irqchk(1'b0);
		rdchk(IRQ_STATUS_ADDR, 32'h0);
		rdchk(LINE_STATUS_REG_ADDR, 32'h21);
		rdchk(SHADOW_RX_TX_DATA_3_ADDR, 32'h11);
		rdchk(LINE_STATUS_REG_ADDR, 32'h20);
		chk(32'(data_rdy), 32'h0);
		u_uart_link_partner.send(1'b0, 8'h22);
		u_uart_link_partner.send(1'b0, 8'h33);
		// overrun lands on the edge that send returns on
		@(posedge clk_i);
		chk(32'(ovr), 32'h1);
		rdchk(LINE_STATUS_REG_ADDR, 32'h23);
		rdchk(SHADOW_RX_TX_DATA_4_ADDR, 32'h33);
		rdchk(LINE_STATUS_REG_ADDR, 32'h20);
		for (int i = 0; i < 16; i++) begin
			u_uart_link_partner.send(1'b0, 8'(8'h80 + i));
			rdchk(ALIAS_BASE_ADDR + 32'(4 * i), 32'h80 + i);
		end
		apb(1'b1, FIFO_CONTROL_REG_ADDR, 32'h1);
		@(posedge clk_i);
		chk(32'(fifo_en), 32'h1);
		for (int i = 0; i < 17; i++)
			u_uart_link_partner.send(1'b0, 8'(8'h30 + i));
		rdchk(LINE_STATUS_REG_ADDR, 32'h23);
		for (int i = 0; i < 16; i++)
			rdchk(SHADOW_RX_TX_DATA_3_ADDR, 32'h30 + i);
		rdchk(LINE_STATUS_REG_ADDR, 32'h20);
		u_uart_link_partner.set_ready(1'b0);
		for (int i = 0; i < 17; i++)
			apb(1'b1, SHADOW_RX_TX_DATA_3_ADDR, 32'h140 + i);
		u_uart_link_partner.set_ready(1'b1);
		wait_tx(16);
		for (int i = 0; i < 16; i++)
			chk(32'(u_uart_link_partner.got[i]), 32'h40 + i);
		apb(1'b1, FIFO_CONTROL_REG_ADDR, 32'h0);
		u_uart_link_partner.got.delete();
		u_uart_link_partner.set_ready(1'b0);
		repeat (2) @(posedge clk_i);
		chk(32'(tx_empty), 32'h1);
		apb(1'b1, SHADOW_RX_TX_DATA_4_ADDR, 32'h3c);
		repeat (2) @(posedge clk_i);
		chk(32'(tx_empty), 32'h0);
		apb(1'b1, SHADOW_RX_TX_DATA_4_ADDR, 32'h1a5);
		// low byte lane off: the data port must ignore this write
		pstrb <= 4'he;
		apb(1'b1, SHADOW_RX_TX_DATA_4_ADDR, 32'h55);
		pstrb <= 4'hf;
		u_uart_link_partner.set_ready(1'b1);
		wait_tx(1);
		chk(32'(u_uart_link_partner.got[0]), 32'ha5);
		chk(32'(tx_empty), 32'h1);
		apb(1'b1, FIFO_CONTROL_REG_ADDR, 32'h2);
		@(posedge clk_i);
		chk(32'(ir_mode), 32'h1);
		u_uart_link_partner.got.delete();
		u_uart_link_partner.send(1'b1, 8'h9c);
		u_uart_link_partner.send(1'b0, 8'h77);
		rdchk(LINE_STATUS_REG_ADDR, 32'h21);
		rdchk(SHADOW_RX_TX_DATA_3_ADDR, 32'h9c);
		rdchk(LINE_STATUS_REG_ADDR, 32'h20);
		apb(1'b1, SHADOW_RX_TX_DATA_3_ADDR, 32'h6d);
		wait_tx(1);
		chk(32'(u_uart_link_partner.got[0]), 32'h16d);
		results();
	end
endmodule : uart_shadow_data_port_tb
